/* src/uart_infrared_codec_status_flags.sv */
// infrared pulse encoder/decoder and serial status flags, avalon-mm register slave
// assumes the shifters, baud generator and framing sit outside; osr_tick is one
// clk-wide pulse per oversampling clock and all inputs are synchronous to clk
//
// Notes on behaviour
// R1: zero bit sends one pulse, one sends none
// R2: pulse at bit start, one to four ticks
// R3: transmit flip selects low or high pulse
// R4: received pulse means zero, none means one
// R5: receive flip selects expected pulse polarity
// R6: only 2.4 to 115.2 kbit/s needed
// R7: buffer-empty flag, interrupt when enabled
// R8: complete flag after all sent, interrupt enabled
// R9: flags update even with interrupts disabled
// R10: reading data clears buffer-full flag
// R11: idle flag cleared only by writing one
// R12: idle rearms only after a new character
// R13: error flags set with buffer-full flag
// R14: overrun character leaves error flags alone
// R15: full buffer on arrival sets overrun, discards
// R16: match flags set with buffer-full flag
// R17: active receive edge sets flag, write-one clears
// R18: edge detection only while receiver enabled
// R19: rising edges in first half ignored
// R20: late rising edge gives zero, restarts count
// R21: no edge for full count gives one
// R22: two-bit width setting, only in infrared mode
`include "uart_ir_map.svh"
`timescale 1ns/1ps
`default_nettype none

module uart_infrared_codec_status_flags #(
  parameter int OSR_W = 5
) (
  input wire logic clk,
  input wire logic nrst,
  // avalon-mm slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // from the surrounding transmitter
  input wire logic osr_tick,
  input wire logic tx_bit_start,
  input wire logic tx_bit,
  input wire logic tx_buffer_room,
  input wire logic tx_all_sent,
  output logic tx_load,
  output logic [9:0] tx_data,
  // from the surrounding receiver
  input wire logic rx_char_valid,
  input wire uart_ir_pkg::rx_char_t rx_char,
  input wire logic rx_idle_detect,
  output logic rx_serial,
  // pins and request
  input wire logic rxd_pin,
  output logic txd_pin,
  output logic irq
);

  uart_ir_pkg::ctrl_t ctrl;
  logic [31:0] ctrl_word;
  logic [9:0] first_match_value;
  logic [9:0] second_match_value;
  logic receive_polarity_flip;
  logic tx_buffer_empty_flag;
  logic tx_complete_flag;
  logic rx_buffer_full_flag;
  logic idle_flag;
  logic idle_armed;
  logic overrun_flag;
  logic rx_noise_flag;
  logic rx_framing_error_flag;
  logic rx_parity_error_flag;
  logic first_match_flag;
  logic second_match_flag;
  logic rx_pin_edge_flag;
  logic [9:0] rx_data;

  // bus decode
  wire logic req = read | write;
  wire logic take = req & ~waitrequest;
  wire logic take_wr = take & write;
  wire logic take_rd = take & read;
  wire logic [31:0] lane_mask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                                 {8{byteenable[1]}}, {8{byteenable[0]}}};
  wire logic [31:0] wbits = writedata & lane_mask;
  wire logic hit_ctrl = address == `UART_IR_OFS_CTRL;
  wire logic hit_stat = address == `UART_IR_OFS_STAT;
  wire logic hit_data = address == `UART_IR_OFS_DATA;
  wire logic hit_match = address == `UART_IR_OFS_MATCH;
  wire logic [31:0] stat_clr = (take_wr && hit_stat) ? wbits : 32'h00000000;
  wire logic data_read = take_rd & hit_data;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [31:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction

  // bit 7 of the control word is spare and not part of the packed control
  assign ctrl = uart_ir_pkg::ctrl_t'({ctrl_word[12:8], ctrl_word[6:0]});

  wire logic [31:0] stat_word = {20'h00000, receive_polarity_flip, rx_pin_edge_flag,
    second_match_flag, first_match_flag, rx_parity_error_flag, rx_framing_error_flag,
    rx_noise_flag, overrun_flag, idle_flag, rx_buffer_full_flag, tx_complete_flag,
    tx_buffer_empty_flag};
  wire logic [31:0] match_word = {6'h00, second_match_value, 6'h00, first_match_value};
  wire logic [31:0] match_merged = merge(match_word, writedata, lane_mask);
  wire logic [31:0] next_readdata = hit_ctrl ? {19'h00000, ctrl_word[12:0]} :
                                    hit_stat ? stat_word :
                                    hit_data ? {22'h000000, rx_data} :
                                    hit_match ? match_word : 32'h00000000;

  // one wait state: waitrequest drops the cycle after a request appears
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
    end else begin
      waitrequest <= ~(req & waitrequest);
      if (req && waitrequest) begin
        readdata <= next_readdata;
      end
    end
  end

  // control, match and flip registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_word <= `UART_IR_CTRL_RESET;
      first_match_value <= 10'h000;
      second_match_value <= 10'h000;
      receive_polarity_flip <= 1'b0;
    end else if (take_wr) begin
      if (hit_ctrl) begin
        ctrl_word <= merge(ctrl_word, writedata, lane_mask) & 32'h00001fff;
      end
      if (hit_match) begin
        first_match_value <= match_merged[9:0];
        second_match_value <= match_merged[`UART_IR_MATCH_SECOND_LO +: 10];
      end
      if (hit_stat && byteenable[1]) begin
        receive_polarity_flip <= writedata[`UART_IR_STAT_RXFLIP];
      end
    end
  end

  // transmit data buffer write goes straight to the surrounding transmitter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_load <= 1'b0;
      tx_data <= 10'h000;
    end else begin
      tx_load <= take_wr & hit_data;
      if (take_wr && hit_data) begin
        tx_data <= writedata[9:0];
      end
    end
  end

  // transmit flags and the single request line
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_buffer_empty_flag <= 1'b1;
      tx_complete_flag <= 1'b1;
      irq <= 1'b0;
    end else begin
      tx_buffer_empty_flag <= tx_buffer_room; // R7 R9
      tx_complete_flag <= tx_all_sent & ~tx_load; // R8 R9
      irq <= (tx_buffer_empty_flag & ctrl.tx_buffer_irq_enable) | // R7
             (tx_complete_flag & ctrl.tx_complete_irq_enable); // R8
    end
  end

  // receive character handling; a data read in the arrival cycle frees the buffer
  wire logic rx_accept = rx_char_valid & (~rx_buffer_full_flag | data_read);
  wire logic rx_overrun = rx_char_valid & rx_buffer_full_flag & ~data_read; // R15

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_data <= 10'h000;
      rx_buffer_full_flag <= 1'b0;
      overrun_flag <= 1'b0;
      rx_noise_flag <= 1'b0;
      rx_framing_error_flag <= 1'b0;
      rx_parity_error_flag <= 1'b0;
      first_match_flag <= 1'b0;
      second_match_flag <= 1'b0;
    end else begin
      if (rx_accept) begin
        rx_data <= rx_char.data;
      end
      rx_buffer_full_flag <= rx_accept | (rx_buffer_full_flag & ~data_read); // R10
      overrun_flag <= rx_overrun | (overrun_flag & ~stat_clr[`UART_IR_STAT_OR]); // R15
      // error and match flags only from accepted characters, set beats clear
      rx_noise_flag <= (rx_accept & rx_char.noise) | // R13 R14
                       (rx_noise_flag & ~stat_clr[`UART_IR_STAT_NF]);
      rx_framing_error_flag <= (rx_accept & rx_char.framing) | // R13 R14
                               (rx_framing_error_flag & ~stat_clr[`UART_IR_STAT_FE]);
      rx_parity_error_flag <= (rx_accept & rx_char.parity) | // R13 R14
                              (rx_parity_error_flag & ~stat_clr[`UART_IR_STAT_PF]);
      first_match_flag <= (rx_accept & (rx_char.data == first_match_value)) | // R16
                          (first_match_flag & ~stat_clr[`UART_IR_STAT_M1]);
      second_match_flag <= (rx_accept & (rx_char.data == second_match_value)) | // R16
                           (second_match_flag & ~stat_clr[`UART_IR_STAT_M2]);
    end
  end

  // idle flag with rearm so a long idle line does not keep setting it
  wire logic idle_set = rx_idle_detect & idle_armed;
  wire logic idle_clr = stat_clr[`UART_IR_STAT_IDLE];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      idle_flag <= 1'b0;
      idle_armed <= 1'b1;
    end else begin
      idle_flag <= idle_set | (idle_flag & ~idle_clr); // R11
      idle_armed <= rx_accept | (idle_armed & ~idle_clr & ~idle_set); // R12
    end
  end

  // receive pin, normalised so idle is high and a pulse is low
  logic rx_level_prev;
  wire logic rx_level = rxd_pin ^ receive_polarity_flip; // R5
  wire logic rx_fall = rx_level_prev & ~rx_level;
  wire logic rx_rise = ~rx_level_prev & rx_level;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_level_prev <= 1'b1;
      rx_pin_edge_flag <= 1'b0;
    end else begin
      rx_level_prev <= rx_level;
      rx_pin_edge_flag <= (rx_fall & ctrl.receiver_enable) | // R17 R18
                          (rx_pin_edge_flag & ~stat_clr[`UART_IR_STAT_EDGE]);
    end
  end

  // infrared decoder; counter saturates at the full oversample count
  logic [OSR_W:0] dec_cnt;
  wire logic [OSR_W:0] osr_full = {1'b0, ctrl.osr_m1} + {{OSR_W{1'b0}}, 1'b1};
  wire logic [OSR_W:0] osr_half = osr_full >> 1;
  wire logic dec_idle = dec_cnt >= osr_full;
  wire logic dec_late_rise = rx_rise & (dec_cnt >= osr_half) & ~dec_idle; // R19 R20
  wire logic dec_start = rx_fall & dec_idle;
  wire logic dec_expire = osr_tick & ~dec_idle & (dec_cnt + 1'b1 >= osr_full); // R21

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dec_cnt <= '1;
      rx_serial <= 1'b1;
    end else if (!ctrl.ir_enable) begin
      dec_cnt <= '1;
      rx_serial <= rx_level;
    end else if (dec_start || dec_late_rise) begin
      dec_cnt <= '0; // R20
      rx_serial <= 1'b0; // R4
    end else if (dec_expire) begin
      dec_cnt <= osr_full;
      rx_serial <= 1'b1; // R4 R21
    end else if (osr_tick && !dec_idle) begin
      dec_cnt <= dec_cnt + {{OSR_W{1'b0}}, 1'b1};
    end
  end

  // infrared encoder; rates above 115.2 kbit/s are not a goal, so the width
  // is counted in oversampling ticks only  R6
  logic [2:0] pulse_left;
  wire logic [2:0] pulse_width = {1'b0, ctrl.pulse_width_sel} + 3'h1; // R22
  wire logic pulse_on = pulse_left != 3'h0;
  wire logic next_pulse = (tx_bit_start & ~tx_bit) | (pulse_on & ~(osr_tick &&
                          pulse_left == 3'h1));

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pulse_left <= 3'h0;
      txd_pin <= 1'b1;
    end else begin
      if (tx_bit_start) begin
        pulse_left <= tx_bit ? 3'h0 : pulse_width; // R1 R2
      end else if (osr_tick && pulse_on) begin
        pulse_left <= pulse_left - 3'h1; // R2
      end
      if (ctrl.ir_enable) begin
        txd_pin <= ~next_pulse ^ ctrl.transmit_polarity_flip; // R3
      end else begin
        txd_pin <= tx_bit ^ ctrl.transmit_polarity_flip;
      end
    end
  end

endmodule

`default_nettype wire

/* src/uart_ir_map.svh */
// register offsets, field positions and reset values of the infrared codec and flags block
// assumes a 32-bit avalon-mm slave with byte addresses, one aligned word per register
`ifndef UART_IR_MAP_SVH
`define UART_IR_MAP_SVH

`define UART_IR_OFS_CTRL 4'h0
`define UART_IR_OFS_STAT 4'h4
`define UART_IR_OFS_DATA 4'h8
`define UART_IR_OFS_MATCH 4'hc

// serial_control_register fields
`define UART_IR_CTRL_TIE 0
`define UART_IR_CTRL_TX_COMPLETE_IRQ_ENABLE 1
`define UART_IR_CTRL_RE 2
`define UART_IR_CTRL_IREN 3
`define UART_IR_CTRL_PW_LO 4
`define UART_IR_CTRL_TXFLIP 6
`define UART_IR_CTRL_OSR_LO 8
`define UART_IR_CTRL_RESET 32'h00000f00

// serial_status_register fields
`define UART_IR_STAT_TX_BUFFER_EMPTY_FLAG 0
`define UART_IR_STAT_TC 1
`define UART_IR_STAT_RX_BUFFER_FULL_FLAG 2
`define UART_IR_STAT_IDLE 3
`define UART_IR_STAT_OR 4
`define UART_IR_STAT_NF 5
`define UART_IR_STAT_FE 6
`define UART_IR_STAT_PF 7
`define UART_IR_STAT_M1 8
`define UART_IR_STAT_M2 9
`define UART_IR_STAT_EDGE 10
`define UART_IR_STAT_RXFLIP 11

// match register: first value low, second value high
`define UART_IR_MATCH_SECOND_LO 16
`define UART_IR_MATCH_RESET 32'h00000000

`endif

/* src/uart_ir_pkg.sv */
// types shared by the infrared codec and flags block
// assumes the field macros of uart_ir_map.svh
package uart_ir_pkg;

  typedef struct packed {
    logic [9:0] data;
    logic noise;
    logic framing;
    logic parity;
  } rx_char_t;

  typedef struct packed {
    logic [4:0] osr_m1;
    logic transmit_polarity_flip;
    logic [1:0] pulse_width_sel;
    logic ir_enable;
    logic receiver_enable;
    logic tx_complete_irq_enable;
    logic tx_buffer_irq_enable;
  } ctrl_t;

endpackage

/* verification/ir_transceiver_model.sv */
// infrared transceiver model: photodiode side drives the receive pin
// assumes osr_tick pulses once per oversampling clock of the block
`timescale 1ns/1ps
`default_nettype none
module ir_transceiver_model (
  input wire logic clk,
  input wire logic osr_tick,
  input wire logic hi_active,
  output logic rxd_pin
);
  initial rxd_pin = 1'b1;
  // a bit lasts the given tick count, so slow and fast rates are both possible
  task automatic send_bit(input logic b, input int w, input int ticks);
    for (int k = 0; k < ticks; k++) begin
      rxd_pin <= (!b && k < w) ? hi_active : !hi_active;
      do @(posedge clk); while (osr_tick !== 1'b1);
    end
  endtask
endmodule
`default_nettype wire

/* verification/uart_infrared_codec_status_flags_tb.sv */
// self-checking bench of the infrared codec and flags block
// assumes the designer's register map and the transceiver model on the pin
`timescale 1ns/1ps
`default_nettype none
module uart_infrared_codec_status_flags_tb;
  logic clk = 1'b0, nrst = 1'b0, read = 1'b0, write = 1'b0;
  logic [3:0] address = 4'h0;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic waitrequest, tx_load, rx_serial, txd_pin, irq, rxd_pin;
  logic [9:0] tx_data;
  logic osr_tick = 1'b0, tx_bit_start = 1'b0, tx_bit = 1'b1, rx_char_valid = 1'b0;
  logic tx_buffer_room = 1'b1, tx_all_sent = 1'b1, rx_idle_detect = 1'b0, rx_hi = 1'b0;
  uart_ir_pkg::rx_char_t rx_char = '0;
  logic [1:0] div = 2'h0;
  int fail_count = 0, compares = 0, cyc = 0;
  always #4 clk = ~clk;
  uart_infrared_codec_status_flags uart_infrared_codec_status_flags_i (.clk, .nrst,
    .address, .read, .write, .byteenable(4'hf), .writedata, .readdata, .waitrequest,
    .osr_tick, .tx_bit_start, .tx_bit, .tx_buffer_room, .tx_all_sent, .tx_load, .tx_data,
    .rx_char_valid, .rx_char, .rx_idle_detect, .rx_serial, .rxd_pin, .txd_pin, .irq);
  ir_transceiver_model ir_transceiver_model_i (.clk, .osr_tick, .hi_active(rx_hi), .rxd_pin);
  task automatic finish_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // tick every fourth cycle keeps a bit at 64 cycles
  always @(posedge clk) begin
    div <= div + 2'h1;
    osr_tick <= (div == 2'h3);
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      finish_test;
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // extra edge after release so the next request never lands in the same step
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] m, e, input string n);
    bus(1'b0, a, 32'h0);
    chk(n, q & m, e);
  endtask
  task automatic push(input logic [12:0] c);
    rx_char <= c;
    rx_char_valid <= 1'b1;
    @(posedge clk);
    rx_char_valid <= 1'b0;
    @(posedge clk);
  endtask
  task automatic idle_pulse;
    rx_idle_detect <= 1'b1;
    @(posedge clk);
    rx_idle_detect <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_irq;
    rdc(4'h0, 32'hffffffff, 32'h00000f00, "ctrl reset");
    rdc(4'h4, 32'h3, 32'h3, "tx flags reset");
    chk("irq masked", irq, 0);
    wr(4'h0, 32'h00000f01);
    repeat (2) @(posedge clk);
    chk("irq empty", irq, 1);
    tx_buffer_room <= 1'b0;
    tx_all_sent <= 1'b0;
    repeat (3) @(posedge clk);
    chk("irq no room", irq, 0);
    rdc(4'h4, 32'h3, 32'h0, "tx flags busy");
    wr(4'h0, 32'h00000f02);
    tx_all_sent <= 1'b1;
    repeat (3) @(posedge clk);
    chk("irq complete", irq, 1);
    wr(4'h0, 32'h00000f00);
    tx_buffer_room <= 1'b1;
    repeat (3) @(posedge clk);
    chk("irq off", irq, 0);
    rdc(4'h4, 32'h3, 32'h3, "polled flags");
    wr(4'h8, 32'h00000123);
    chk("tx data", tx_data, 32'h123);
    tx_bit <= 1'b0;
    repeat (3) @(posedge clk);
    chk("plain level", txd_pin, 0);
    tx_bit <= 1'b1;
  endtask
  task automatic t_rx;
    wr(4'hc, 32'h015502aa);
    push({10'h2aa, 3'b101});
    rdc(4'h4, 32'h3fc, 32'h1a4, "flags with char");
    push({10'h155, 3'b010});
    rdc(4'h4, 32'h3fc, 32'h1b4, "overrun flags");
    rdc(4'h8, 32'h3ff, 32'h2aa, "kept char");
    rdc(4'h4, 32'h4, 32'h0, "full after read");
    wr(4'h4, 32'h000003f0);
    push({10'h155, 3'b000});
    rdc(4'h4, 32'h3fc, 32'h204, "second match");
    rdc(4'h8, 32'h3ff, 32'h155, "matched char");
    idle_pulse;
    wr(4'h4, 32'h0);
    rdc(4'h4, 32'h8, 32'h8, "idle kept");
    wr(4'h4, 32'h8);
    rdc(4'h4, 32'h8, 32'h0, "idle cleared");
    idle_pulse;
    rdc(4'h4, 32'h8, 32'h0, "idle disarmed");
    push({10'h001, 3'b000});
    idle_pulse;
    rdc(4'h4, 32'h8, 32'h8, "idle rearmed");
  endtask
  task automatic tx_pulse(input logic b, input logic f, input int e);
    int n;
    n = 0;
    tx_bit <= b;
    tx_bit_start <= 1'b1;
    @(posedge clk);
    tx_bit_start <= 1'b0;
    repeat (40) begin
      @(posedge clk);
      if (txd_pin === f && osr_tick === 1'b1) n++;
    end
    chk("pulse ticks", n, e);
    tx_bit <= 1'b1;
  endtask
  task automatic t_irtx;
    for (int f = 0; f < 2; f++) begin
      for (int s = 0; s < 4; s++) begin
        wr(4'h0, 32'h00000f0c | (s << 4) | (f << 6));
        repeat (8) @(posedge clk);
        tx_pulse(1'b0, f[0], s + 1);
        tx_pulse(1'b1, f[0], 0);
      end
    end
  endtask
  task automatic t_irrx;
    for (int f = 0; f < 2; f++) begin
      rx_hi <= f[0];
      wr(4'h4, f << 11);
      ir_transceiver_model_i.send_bit(1'b1, 2, 16);
      wr(4'h4, (f << 11) | 32'h400);
      rdc(4'h4, 32'h400, 32'h0, "edge cleared");
      fork
        ir_transceiver_model_i.send_bit(1'b0, 2, 16);
        begin
          repeat (30) @(posedge clk);
          chk("zero decoded", rx_serial, 0);
        end
      join
      ir_transceiver_model_i.send_bit(1'b1, 2, 16);
      chk("one decoded", rx_serial, 1);
      rdc(4'h4, 32'h400, 32'h400, "edge seen");
    end
    wr(4'h0, 32'h00000f08);
    wr(4'h4, 32'h00000c00);
    ir_transceiver_model_i.send_bit(1'b0, 2, 16);
    rdc(4'h4, 32'h400, 32'h0, "edge off");
  endtask
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_irq;
    t_rx;
    t_irtx;
    t_irrx;
    finish_test;
  end
endmodule
`default_nettype wire

/* verification/uart_ir_monitor.sv */
// port checker of the infrared codec and flags block
// assumes a bind to the block; control bits are mirrored from bus writes
`timescale 1ns/1ps
`default_nettype none
module uart_ir_monitor (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic waitrequest,
  input wire logic tx_bit_start,
  input wire logic tx_bit,
  input wire logic tx_load,
  input wire logic [9:0] tx_data,
  input wire logic rxd_pin,
  input wire logic rx_serial,
  input wire logic txd_pin,
  input wire logic irq
);
  // mirror only holds full-word writes, the bench never masks lanes
  logic [6:0] ctl;
  logic rflip;
  wire acc = write && !waitrequest;
  wire ir = ctl[3];
  wire ir_off = !ctl[3];
  wire tflip = ctl[6];
  wire en = ctl[0] | ctl[1];
  wire tx_lvl = tx_bit ^ ctl[6];
  wire norm = rxd_pin ^ rflip;
  wire [9:0] wd_lo = writedata[9:0];
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctl <= 7'h00;
      rflip <= 1'b0;
    end else begin
      if (acc && address == 4'h0) ctl <= writedata[6:0];
      if (acc && address == 4'h4) rflip <= writedata[11];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered");
  bus_once_a: assert property (!waitrequest |=> waitrequest)
    else $error("answer longer than one cycle");
  data_load_a: assert property (acc && address == 4'h8 |=> tx_load && tx_data == $past(wd_lo))
    else $error("data write not handed on");
  zero_pulse_a:
    assert property (ir && tx_bit_start && !tx_bit |=> txd_pin == $past(tflip))
    else $error("zero bit without pulse");
  one_quiet_a:
    assert property (ir && tx_bit_start && tx_bit |=> txd_pin != $past(tflip))
    else $error("one bit with pulse");
  irq_mask_a:
    assert property (irq |-> $past(en))
    else $error("request while masked");
  plain_tx_a:
    assert property (ir_off && $past(ir_off) |-> txd_pin == $past(tx_lvl))
    else $error("plain level wrong");
  rx_zero_a:
    assert property (ir && $fell(norm) |=> !rx_serial)
    else $error("pulse not decoded as zero");
  cover property (ir && tx_bit_start && !tx_bit);
  cover property (irq);
  cover property (ir && $fell(rx_serial));
endmodule
bind uart_infrared_codec_status_flags uart_ir_monitor uart_ir_monitor_i (.clk, .nrst,
  .address, .read, .write, .writedata, .waitrequest, .tx_bit_start, .tx_bit, .tx_load,
  .tx_data, .rxd_pin, .rx_serial, .txd_pin, .irq);
`default_nettype wire
